/* File: shared/cdsc_pkg.sv */
// package: register map, field layout, reset values and timing for the cable diag register bank
package cdsc_pkg;
    // ------------------------------------------------------------
    // register offsets (word index = byte address on this port)
    // ------------------------------------------------------------
    localparam logic [7:0] CDSC_OFF_PAIR = 8'h16;
    localparam logic [7:0] CDSC_OFF_SWING = 8'h1a;
    localparam logic [7:0] CDSC_OFF_BYPASS = 8'h1b;
    localparam logic [7:0] CDSC_OFF_RESULT = 8'h1c;
    localparam logic [7:0] CDSC_OFF_CTRL = 8'h30;
    localparam logic [7:0] CDSC_OFF_IRQ_STAT = 8'h31;
    localparam logic [7:0] CDSC_OFF_IRQ_EN = 8'h32;
    localparam logic [7:0] CDSC_OFF_IRQ_CLR = 8'h33;
    localparam logic [7:0] CDSC_OFF_LINK = 8'h34;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CDSC_BYP_EN_BIT = 12;
    localparam int CDSC_BYP_ST_BIT = 11;
    localparam int CDSC_DIAG_EN_BIT = 15;
    localparam int CDSC_SWRST_BIT = 0;
    localparam int CDSC_IRQ_DIAG_BIT = 0;
    localparam int CDSC_IRQ_LOCK_BIT = 1;
    localparam int CDSC_IRQ_BYP_BIT = 2;
    localparam int CDSC_LOCKLOST_BIT = 15;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CDSC_SWING_RST = 3'h2;
    localparam logic [4:0] CDSC_SW26_RSV_RST = 5'h01;
    localparam logic [2:0] CDSC_ST27_HI_RST = 3'h4;
    localparam logic [10:0] CDSC_ST27_LO_RST = 11'h008;
    localparam logic CDSC_BYP_EN_RST = 1'b1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CDSC_CLK_HZ = 10000000;
    localparam int CDSC_BYPASS_MS = 200;
    localparam int CDSC_IDLE_MS = 1;
    localparam int CDSC_BYPASS_CYC = CDSC_CLK_HZ / 1000 * CDSC_BYPASS_MS;
    localparam int CDSC_IDLE_CYC = CDSC_CLK_HZ / 1000 * CDSC_IDLE_MS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CDSC_RES_NONE,
        CDSC_RES_SHORT,
        CDSC_RES_OPEN,
        CDSC_RES_FAIL
    } cdsc_result_e;
    typedef struct packed {
        cdsc_result_e status;
        logic [4:0] magnitude;
        logic [7:0] distance;
    } cdsc_pair_s;
endpackage : cdsc_pkg

/* File: core/cdsc_regs.sv */
// cable diagnostic, output swing and base-x bypass register bank
//
// Contract
// - pair select picks reported channel A-D
// - three-bit swing, hw reset 010, sw retain
// - bypass enable, taken over at sw reset, brings link up after 200ms
// - read-only bypass status, kept over sw reset
// - diagnostic runs only while link down
// - test proceeds despite partner negotiating/pulses
// - result 11 fail 10 open 01 short
// - five-bit reflected magnitude code per pair
// - eight-bit distance code N reported
// - distance zero when no short/open
// - no idles in 1ms sets lock lost
`timescale 1ns/1ps
module cdsc_regs
    import cdsc_pkg::*;
#(
    parameter int BYPASS_CYC = CDSC_BYPASS_CYC,
    parameter int IDLE_CYC = CDSC_IDLE_CYC
) (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // link side (pins, synchronised here)
    input wire logic LINK_UP_PIN,
    input wire logic IDLE_SEEN_PIN,
    input wire logic AN_DONE_PIN,
    // measurement engine (same clock)
    input wire logic MEAS_DONE,
    input wire cdsc_pair_s [3:0] MEAS_RESULT,
    output logic MEAS_START,
    // controls out
    output logic [2:0] SWING,
    output logic BASEX_LINK_UP,
    output logic LINK_DOWN_REQ,
    output logic IRQ
);
    // ------------------------------------------------------------
    // reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_reg <= 2'h0;
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
            pin_s1_reg <= {AN_DONE_PIN, IDLE_SEEN_PIN, LINK_UP_PIN};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign rst_n = rst_sync_reg[1];
    logic link_up;
    logic idle_seen;
    logic an_done;
    assign link_up = pin_s2_reg[0];
    assign idle_seen = pin_s2_reg[1];
    assign an_done = pin_s2_reg[2];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CDSC_T_IDLE, CDSC_T_WAIT, CDSC_T_RUN} cdsc_test_e;
    logic [1:0] pair_reg, pair_next;
    logic [2:0] swing_reg, swing_next;
    logic [4:0] rsv26_reg, rsv26_next;
    logic [2:0] hi27_reg, hi27_next;
    logic [10:0] lo27_reg, lo27_next;
    logic byp_en_reg, byp_en_next;
    logic byp_act_reg, byp_act_next;
    logic byp_st_reg, byp_st_next;
    logic diag_en_reg, diag_en_next;
    cdsc_pair_s [3:0] res_reg, res_next;
    cdsc_test_e test_reg, test_next;
    logic start_reg, start_next;
    logic [27:0] byp_cnt_reg, byp_cnt_next;
    logic basex_up_reg, basex_up_next;
    logic [23:0] idle_cnt_reg, idle_cnt_next;
    logic lock_lost_reg, lock_lost_next;
    logic [2:0] irq_st_reg, irq_st_next;
    logic [2:0] irq_en_reg, irq_en_next;
    logic irq_reg, irq_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [2:0] ev;
    logic sw_rst;
    logic wr_pair, wr_swing, wr_byp, wr_res;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        cdsc_pair_s sel;
        sel = res_reg[pair_reg];
        wr_pair = WR && ADDR == CDSC_OFF_PAIR;
        wr_swing = WR && ADDR == CDSC_OFF_SWING;
        wr_byp = WR && ADDR == CDSC_OFF_BYPASS;
        wr_res = WR && ADDR == CDSC_OFF_RESULT;
        sw_rst = WR && ADDR == CDSC_OFF_CTRL && WDATA[CDSC_SWRST_BIT];
        pair_next = wr_pair ? WDATA[1:0] : pair_reg;
        swing_next = wr_swing ? WDATA[2:0] : swing_reg;
        rsv26_next = wr_swing ? WDATA[7:3] : rsv26_reg;
        hi27_next = wr_byp ? WDATA[15:13] : hi27_reg;
        lo27_next = wr_byp ? WDATA[10:0] : lo27_reg;
        byp_en_next = wr_byp ? WDATA[CDSC_BYP_EN_BIT] : byp_en_reg;
        byp_act_next = sw_rst ? byp_en_reg : byp_act_reg;
        diag_en_next = wr_res ? WDATA[CDSC_DIAG_EN_BIT] : diag_en_reg;
        res_next = res_reg;
        test_next = test_reg;
        start_next = 1'b0;
        ev = 3'h0;
        // diagnostic sequence; partner activity is not a blocker, only link state
        unique case (test_reg)
            CDSC_T_IDLE: begin
                if (diag_en_reg) begin
                    test_next = CDSC_T_WAIT;
                end
            end
            CDSC_T_WAIT: begin
                if (!diag_en_reg) begin
                    test_next = CDSC_T_IDLE;
                end else if (!link_up) begin
                    start_next = 1'b1;
                    test_next = CDSC_T_RUN;
                end
            end
            CDSC_T_RUN: begin
                if (MEAS_DONE) begin
                    for (int i = 0; i < 4; i++) begin
                        res_next[i] = MEAS_RESULT[i];
                        if (MEAS_RESULT[i].status != CDSC_RES_SHORT &&
                            MEAS_RESULT[i].status != CDSC_RES_OPEN) begin
                            res_next[i].distance = 8'h00;
                        end
                    end
                    diag_en_next = wr_res ? WDATA[CDSC_DIAG_EN_BIT] : 1'b0;
                    ev[CDSC_IRQ_DIAG_BIT] = 1'b1;
                    test_next = CDSC_T_IDLE;
                end
            end
            default: test_next = CDSC_T_IDLE;
        endcase
        // base-x bypass timer
        byp_cnt_next = byp_cnt_reg;
        basex_up_next = basex_up_reg;
        byp_st_next = byp_st_reg;
        if (!link_up) begin
            byp_cnt_next = 28'h0;
            basex_up_next = 1'b0;
        end else if (!basex_up_reg) begin
            if (an_done) begin
                basex_up_next = 1'b1;
                byp_st_next = 1'b0;
            end else if (byp_act_reg && byp_cnt_reg >= 28'(BYPASS_CYC - 1)) begin
                basex_up_next = 1'b1;
                byp_st_next = 1'b1;
                ev[CDSC_IRQ_BYP_BIT] = 1'b1;
            end else begin
                byp_cnt_next = byp_cnt_reg + 28'h1;
            end
        end
        // idle watchdog
        idle_cnt_next = idle_cnt_reg;
        lock_lost_next = lock_lost_reg;
        if (!link_up || idle_seen) begin
            idle_cnt_next = 24'h0;
            lock_lost_next = 1'b0;
        end else if (idle_cnt_reg >= 24'(IDLE_CYC - 1)) begin
            if (!lock_lost_reg) begin
                ev[CDSC_IRQ_LOCK_BIT] = 1'b1;
            end
            lock_lost_next = 1'b1;
        end else begin
            idle_cnt_next = idle_cnt_reg + 24'h1;
        end
        // interrupts: set beats clear
        irq_en_next = (WR && ADDR == CDSC_OFF_IRQ_EN) ? WDATA[2:0] : irq_en_reg;
        irq_st_next = irq_st_reg;
        if (WR && ADDR == CDSC_OFF_IRQ_CLR) begin
            irq_st_next = irq_st_reg & ~WDATA[2:0];
        end
        irq_st_next = irq_st_next | ev;
        irq_next = |(irq_st_reg & irq_en_reg);
        // software reset: per-field update values
        if (sw_rst) begin
            rsv26_next = CDSC_SW26_RSV_RST;
            hi27_next[2] = CDSC_ST27_HI_RST[2];
            lo27_next = CDSC_ST27_LO_RST;
            diag_en_next = 1'b0;
            test_next = CDSC_T_IDLE;
            for (int i = 0; i < 4; i++) begin
                res_next[i] = '0;
            end
        end
        // read mux
        rdata_next = 16'h0000;
        if (RD) begin
            unique case (ADDR)
                CDSC_OFF_PAIR: rdata_next = {14'h0000, pair_reg};
                CDSC_OFF_SWING: rdata_next = {8'h00, rsv26_reg, swing_reg};
                CDSC_OFF_BYPASS: rdata_next = {hi27_reg, byp_en_reg, byp_st_reg, lo27_reg};
                CDSC_OFF_RESULT: rdata_next = {diag_en_reg, sel};
                CDSC_OFF_IRQ_STAT: rdata_next = {13'h0000, irq_st_reg};
                CDSC_OFF_IRQ_EN: rdata_next = {13'h0000, irq_en_reg};
                CDSC_OFF_LINK: rdata_next = {lock_lost_reg, 12'h000, an_done,
                                            basex_up_reg, link_up};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers (hardware reset values)
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pair_reg <= 2'h0;
            swing_reg <= CDSC_SWING_RST;
            rsv26_reg <= CDSC_SW26_RSV_RST;
            hi27_reg <= CDSC_ST27_HI_RST;
            lo27_reg <= CDSC_ST27_LO_RST;
            byp_en_reg <= CDSC_BYP_EN_RST;
            byp_act_reg <= CDSC_BYP_EN_RST;
            byp_st_reg <= 1'b0;
            diag_en_reg <= 1'b0;
            res_reg <= '0;
            test_reg <= CDSC_T_IDLE;
            start_reg <= 1'b0;
            byp_cnt_reg <= 28'h0;
            basex_up_reg <= 1'b0;
            idle_cnt_reg <= 24'h0;
            lock_lost_reg <= 1'b0;
            irq_st_reg <= 3'h0;
            irq_en_reg <= 3'h0;
            irq_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else if (CLK_EN) begin
            pair_reg <= pair_next;
            swing_reg <= swing_next;
            rsv26_reg <= rsv26_next;
            hi27_reg <= hi27_next;
            lo27_reg <= lo27_next;
            byp_en_reg <= byp_en_next;
            byp_act_reg <= byp_act_next;
            byp_st_reg <= byp_st_next;
            diag_en_reg <= diag_en_next;
            res_reg <= res_next;
            test_reg <= test_next;
            start_reg <= start_next;
            byp_cnt_reg <= byp_cnt_next;
            basex_up_reg <= basex_up_next;
            idle_cnt_reg <= idle_cnt_next;
            lock_lost_reg <= lock_lost_next;
            irq_st_reg <= irq_st_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;
    assign MEAS_START = start_reg;
    assign SWING = swing_reg;
    assign BASEX_LINK_UP = basex_up_reg;
    assign LINK_DOWN_REQ = lock_lost_reg;
    assign IRQ = irq_reg;
endmodule : cdsc_regs

/* File: tb/cdsc_regs_props.sv */
// checker: port-level properties of the cable diag register bank
`timescale 1ns/1ps
module cdsc_regs_props
    import cdsc_pkg::*;
#(
    parameter int BYPASS_CYC = CDSC_BYPASS_CYC,
    parameter int IDLE_CYC = CDSC_IDLE_CYC
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic LINK_UP_PIN,
    input wire logic IDLE_SEEN_PIN,
    input wire logic AN_DONE_PIN,
    input wire logic MEAS_DONE,
    input wire cdsc_pair_s [3:0] MEAS_RESULT,
    input wire logic MEAS_START,
    input wire logic [2:0] SWING,
    input wire logic BASEX_LINK_UP,
    input wire logic LINK_DOWN_REQ,
    input wire logic IRQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // margin of 6 covers pin sync plus output register
    int dry_cnt;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dry_cnt <= 0;
        end else if (LINK_UP_PIN && !IDLE_SEEN_PIN && dry_cnt < 100000) begin
            dry_cnt <= dry_cnt + 1;
        end else if (!(LINK_UP_PIN && !IDLE_SEEN_PIN)) begin
            dry_cnt <= 0;
        end
    end
    rd_idle_zero_a: assert property (!RD |=> RDATA == 16'h0) else $error("stray read data");
    pair_rd_a: assert property (RD && ADDR == CDSC_OFF_PAIR |=> RDATA[15:2] == 14'h0)
        else $error("pair select upper bits set");
    swing_rd_a: assert property (RD && ADDR == CDSC_OFF_SWING |=> RDATA[2:0] == $past(SWING))
        else $error("swing readback differs from pins");
    dist_zero_a: assert property (RD && ADDR == CDSC_OFF_RESULT |=>
        (RDATA[14] != RDATA[13] || RDATA[7:0] == 8'h0)) else $error("distance without fault");
    start_pulse_a: assert property (MEAS_START |=> !MEAS_START) else $error("start too long");
    // pin passes two sync stages and the start register: three edges back
    start_down_a: assert property (MEAS_START |-> !$past(LINK_UP_PIN, 3))
        else $error("measurement with link up");
    basex_link_a: assert property ($rose(BASEX_LINK_UP) |-> $past(LINK_UP_PIN, 3))
        else $error("base-x up without link");
    lock_early_a: assert property ($rose(LINK_DOWN_REQ) |-> dry_cnt >= IDLE_CYC)
        else $error("lock lost too early");
    lock_late_a: assert property (dry_cnt == IDLE_CYC + 6 |-> LINK_DOWN_REQ)
        else $error("lock lost missing");
endmodule : cdsc_regs_props

bind cdsc_regs cdsc_regs_props #(.BYPASS_CYC(BYPASS_CYC), .IDLE_CYC(IDLE_CYC)) chk_u (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_UP_PIN(LINK_UP_PIN), .IDLE_SEEN_PIN(IDLE_SEEN_PIN),
    .AN_DONE_PIN(AN_DONE_PIN), .MEAS_DONE(MEAS_DONE), .MEAS_RESULT(MEAS_RESULT),
    .MEAS_START(MEAS_START), .SWING(SWING), .BASEX_LINK_UP(BASEX_LINK_UP),
    .LINK_DOWN_REQ(LINK_DOWN_REQ), .IRQ(IRQ));

/* File: tb/cdsc_meas_model.sv */
// measurement engine model: answers each start with a fixed four-pair result
`timescale 1ns/1ps
module cdsc_meas_model
    import cdsc_pkg::*;
#(
    parameter int DLY = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // engine handshake
    input wire logic start,
    output logic done,
    output cdsc_pair_s [3:0] result
);
    localparam cdsc_pair_s [3:0] RES = {cdsc_pair_s'{CDSC_RES_FAIL, 5'h08, 8'h11},
        cdsc_pair_s'{CDSC_RES_NONE, 5'h00, 8'h55}, cdsc_pair_s'{CDSC_RES_OPEN, 5'h10, 8'h80},
        cdsc_pair_s'{CDSC_RES_SHORT, 5'h1f, 8'h40}};
    int cnt;
    // result toggles outside the done cycle so stale data is never mistaken for fresh
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            done <= 1'b0;
            result <= ~RES;
        end else begin
            done <= 1'b0;
            result <= ~result;
            if (start) begin
                cnt <= DLY;
            end else if (cnt == 1) begin
                cnt <= 0;
                done <= 1'b1;
                result <= RES;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : cdsc_meas_model

/* File: tb/cable_diag_serdes_ctrl_regs_tb.sv */
// testbench: register, bypass, diagnostic and lock-lost scenarios
`timescale 1ns/1ps
module cable_diag_serdes_ctrl_regs_tb;
    import cdsc_pkg::*;
    localparam int BYP = 50;
    localparam int IDL = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic link_up = 1'b0;
    logic idle_seen = 1'b1;
    logic clk_en = 1'b1;
    logic an_done = 1'b0;
    logic [15:0] rdata;
    logic meas_done, meas_start, basex_up, down_req, irq, idle_pin;
    logic [2:0] swing;
    cdsc_pair_s [3:0] meas_res;
    logic [15:0] exp_tab [4] = '{16'h3f40, 16'h5080, 16'h0000, 16'h6800};
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    // link pulses keep arriving while the link is down
    assign idle_pin = link_up ? idle_seen : cyc[2];
    cdsc_regs #(.BYPASS_CYC(BYP), .IDLE_CYC(IDL)) dut_u (.REF_CLK(clk), .ARST_N(arst_n),
        .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .LINK_UP_PIN(link_up), .IDLE_SEEN_PIN(idle_pin), .AN_DONE_PIN(an_done),
        .MEAS_DONE(meas_done), .MEAS_RESULT(meas_res), .MEAS_START(meas_start), .SWING(swing),
        .BASEX_LINK_UP(basex_up), .LINK_DOWN_REQ(down_req), .IRQ(irq));
    cdsc_meas_model meas_u (.clk(clk), .rst_n(arst_n), .start(meas_start), .done(meas_done),
        .result(meas_res));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_reg
    // sel 0 watches the base-x link, sel 1 the lock-lost request
    task automatic wait_hi(input bit sel, input int lim);
        for (int i = 0; i < lim && (sel ? down_req : basex_up) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({15'h0, sel ? down_req : basex_up}, 16'h0001);
    endtask : wait_hi
    task automatic wrap_up;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({13'h0, swing}, 16'h0002);
        rd_reg(CDSC_OFF_PAIR, 16'h0000);
        rd_reg(CDSC_OFF_SWING, 16'h000a);
        rd_reg(CDSC_OFF_BYPASS, 16'h9008);
        rd_reg(CDSC_OFF_RESULT, 16'h0000);
        rd_reg(8'h00, 16'h0000);
        // a write while the clock enable is low must be lost
        clk_en <= 1'b0;
        wr_reg(CDSC_OFF_PAIR, 16'h0003);
        clk_en <= 1'b1;
        rd_reg(CDSC_OFF_PAIR, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr_reg(CDSC_OFF_SWING, 16'h0008 | 16'(c));
            rd_reg(CDSC_OFF_SWING, 16'h0008 | 16'(c));
        end
        check({13'h0, swing}, 16'h0007);
        wr_reg(CDSC_OFF_BYPASS, 16'h8008);
        wr_reg(CDSC_OFF_CTRL, 16'h0001);
        rd_reg(CDSC_OFF_SWING, 16'h000f);
        rd_reg(CDSC_OFF_BYPASS, 16'h8008);
        wr_reg(CDSC_OFF_IRQ_EN, 16'h0007);
        link_up <= 1'b1;
        repeat (BYP + 20) @(posedge clk);
        check({15'h0, basex_up}, 16'h0000);
        link_up <= 1'b0;
        wr_reg(CDSC_OFF_BYPASS, 16'h9008);
        wr_reg(CDSC_OFF_CTRL, 16'h0001);
        link_up <= 1'b1;
        wait_hi(1'b0, BYP + 20);
        rd_reg(CDSC_OFF_BYPASS, 16'h9808);
        check({15'h0, irq}, 16'h0001);
        wr_reg(CDSC_OFF_IRQ_CLR, 16'h0004);
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, irq}, 16'h0000);
        wr_reg(CDSC_OFF_CTRL, 16'h0001);
        rd_reg(CDSC_OFF_BYPASS, 16'h9808);
        wr_reg(CDSC_OFF_RESULT, 16'h8000);
        repeat (20) @(posedge clk);
        rd_reg(CDSC_OFF_RESULT, 16'h8000);
        link_up <= 1'b0;
        repeat (40) @(posedge clk);
        rd_reg(CDSC_OFF_IRQ_STAT, 16'h0001);
        for (int p = 0; p < 4; p++) begin
            wr_reg(CDSC_OFF_PAIR, 16'(p));
            rd_reg(CDSC_OFF_RESULT, exp_tab[p]);
        end
        link_up <= 1'b1;
        idle_seen <= 1'b0;
        wait_hi(1'b1, IDL + 20);
        rd_reg(CDSC_OFF_IRQ_STAT, 16'h0003);
        repeat (8) @(posedge clk);
        // regular negotiation completes: status must fall back to 0
        link_up <= 1'b0;
        idle_seen <= 1'b1;
        an_done <= 1'b1;
        repeat (4) @(posedge clk);
        link_up <= 1'b1;
        wait_hi(1'b0, 20);
        rd_reg(CDSC_OFF_BYPASS, 16'h9008);
        wrap_up();
    end
endmodule : cable_diag_serdes_ctrl_regs_tb
